// File: rtl/mfrl_pkg.sv
`default_nettype none
package mfrl_pkg;
    localparam logic [5:0] MFRL_ADDR_CTRL = 6'h00;
    localparam logic [5:0] MFRL_ADDR_CTRL_STAT = 6'h04;
    localparam logic [5:0] MFRL_ADDR_DRV_STAT = 6'h08;
    localparam logic [5:0] MFRL_ADDR_IRQ_STAT = 6'h0C;
    localparam logic [5:0] MFRL_ADDR_IRQ_MASK = 6'h10;
    localparam logic [5:0] MFRL_ADDR_RETRY = 6'h14;
    localparam int MFRL_CTRL_CBC_LSB = 0;
    localparam int MFRL_CTRL_LOCK_LSB = 4;
    localparam int MFRL_CTRL_THERM_BIT = 8;
    localparam int MFRL_CTRL_CLEAR_BIT = 31;
    localparam int MFRL_RETRY_CYC_LSB = 0;
    localparam int MFRL_RETRY_LOCK_LSB = 8;
    localparam logic [31:0] MFRL_CTRL_RESET = 32'h0000_0077;
    localparam logic [31:0] MFRL_RETRY_RESET = 32'h0000_6404;
    localparam int MFRL_POS_TIMEOUT_MS = 500;
    localparam int MFRL_CLK_MHZ = 100;
    localparam int MFRL_POS_TIMEOUT_CYC = MFRL_POS_TIMEOUT_MS * 1000 * MFRL_CLK_MHZ;
    localparam int MFRL_LOCK_TICK_US = 1000;
    localparam int MFRL_LOCK_TICK_CYC = MFRL_LOCK_TICK_US * MFRL_CLK_MHZ;
    localparam logic [1:0] MFRL_RESP_OK = 2'h0;
    localparam logic [1:0] MFRL_RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        MFRL_DRV_ACTIVE, MFRL_DRV_PULL_LOW, MFRL_DRV_RECIRC, MFRL_DRV_HS_BRAKE, MFRL_DRV_LS_BRAKE
    } mfrl_drive_t;
    typedef struct packed {
        logic thermal;
        logic lock_current;
        logic pulse_start;
        logic pulse_decayed;
        logic rise_phase;
        logic fall_phase;
        logic cycle_start;
        logic cycle_over;
    } mfrl_sense_t;
    typedef struct packed {
        logic [2:0] high_side_gate;
        logic [2:0] low_side_gate;
    } mfrl_gates_t;
endpackage
`default_nettype wire

// File: rtl/mfrl_gate_mux.sv
`default_nettype none
module mfrl_gate_mux (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Selected action and commanded drive
    input wire mfrl_pkg::mfrl_drive_t drive,
    input wire mfrl_pkg::mfrl_gates_t pwm_gates,
    // Registered gate outputs
    output mfrl_pkg::mfrl_gates_t gates
);
    import mfrl_pkg::*;
    mfrl_gates_t next_gates;
    always_comb begin
        next_gates = pwm_gates;
        case (drive)
            MFRL_DRV_ACTIVE: next_gates = pwm_gates;
            MFRL_DRV_PULL_LOW: next_gates = '0;
            // Recirculation keeps only the low sides the PWM already had on so energy stays in the windings.
            MFRL_DRV_RECIRC: next_gates = '{high_side_gate: 3'h0, low_side_gate: pwm_gates.low_side_gate};
            MFRL_DRV_HS_BRAKE: next_gates = '{high_side_gate: 3'h7, low_side_gate: 3'h0};
            MFRL_DRV_LS_BRAKE: next_gates = '{high_side_gate: 3'h0, low_side_gate: 3'h7};
            default: next_gates = '0;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gates <= '0;
        end else begin
            gates <= next_gates;
        end
    end
endmodule // mfrl_gate_mux
`default_nettype wire

// File: rtl/mfrl_top.sv
`default_nettype none
module mfrl_top #(
    parameter int POS_TIMEOUT_CYC = mfrl_pkg::MFRL_POS_TIMEOUT_CYC,
    parameter int LOCK_TICK_CYC = mfrl_pkg::MFRL_LOCK_TICK_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Fault sensing and commanded drive
    input wire mfrl_pkg::mfrl_sense_t sense,
    input wire mfrl_pkg::mfrl_gates_t pwm_gates,
    // Gate outputs, fault pin and interrupt
    output mfrl_pkg::mfrl_gates_t gates,
    output logic fault_pin_n_out,
    output logic fault_pin_n_oe,
    output logic irq
);
    import mfrl_pkg::*;

    logic [31:0] ctrl;
    logic [31:0] retry;
    logic [7:0] irq_mask;
    logic [7:0] irq_stat;
    logic [3:0] cycle_limit_mode;
    logic [3:0] lock_current_mode;
    logic thermal_auto_recover;
    logic [7:0] cycle_limit_retry_count;
    logic [7:0] lock_retry_time;
    logic clear_fault;
    assign cycle_limit_mode = ctrl[MFRL_CTRL_CBC_LSB +: 4];
    assign lock_current_mode = ctrl[MFRL_CTRL_LOCK_LSB +: 4];
    assign thermal_auto_recover = ctrl[MFRL_CTRL_THERM_BIT];
    assign cycle_limit_retry_count = retry[MFRL_RETRY_CYC_LSB +: 8];
    assign lock_retry_time = retry[MFRL_RETRY_LOCK_LSB +: 8];

    // Write channel: address and data taken in either order, answered once both are held.
    logic aw_held;
    logic w_held;
    logic [5:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic do_read;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= MFRL_RESP_OK;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == MFRL_ADDR_CTRL || aw_addr == MFRL_ADDR_IRQ_MASK ||
                                aw_addr == MFRL_ADDR_RETRY) ? MFRL_RESP_OK : MFRL_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] result;
        result = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                result[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // The clear command is a self-clearing pulse; it never reads back as one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= MFRL_CTRL_RESET;
            retry <= MFRL_RETRY_RESET;
            irq_mask <= '0;
            clear_fault <= 1'b0;
        end else begin
            clear_fault <= 1'b0;
            if (do_write && aw_addr == MFRL_ADDR_CTRL) begin
                ctrl <= merge(ctrl, w_data, w_strb) & ~(32'h1 << MFRL_CTRL_CLEAR_BIT);
                clear_fault <= w_strb[3] && w_data[MFRL_CTRL_CLEAR_BIT];
            end
            if (do_write && aw_addr == MFRL_ADDR_RETRY) begin
                retry <= merge(retry, w_data, w_strb) & 32'h0000_FFFF;
            end
            if (do_write && aw_addr == MFRL_ADDR_IRQ_MASK && w_strb[0]) begin
                irq_mask <= w_data[7:0];
            end
        end
    end

    // Fault state.
    logic cbc_active;
    logic cbc_report;
    logic [7:0] cbc_count;
    logic lock_latched;
    logic lock_retry_wait;
    logic lock_report;
    logic [7:0] lock_count;
    logic [$clog2(LOCK_TICK_CYC+1)-1:0] tick_count;
    logic rise_timeout;
    logic fall_timeout;
    logic rate_fault;
    logic thermal_latched;
    logic [$clog2(POS_TIMEOUT_CYC+1)-1:0] phase_count;
    logic pulse_pending;
    logic lock_tick;

    logic cbc_acts;
    logic cbc_reports;
    assign cbc_acts = (cycle_limit_mode[3:1] != 3'b011) && !cycle_limit_mode[3];
    assign cbc_reports = cbc_acts && !cycle_limit_mode[0] || cycle_limit_mode == 4'b0110;

    // Cycle-by-cycle limit: the PWM count restarts at each overcurrent.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cbc_active <= 1'b0;
            cbc_report <= 1'b0;
            cbc_count <= '0;
        end else if (sense.cycle_over && cycle_limit_mode != 4'b0110 && cbc_acts) begin
            cbc_active <= 1'b1;
            cbc_report <= cbc_reports;
            cbc_count <= '0;
        end else if (sense.cycle_over && cycle_limit_mode == 4'b0110) begin
            cbc_report <= 1'b1;
        end else if (cbc_active) begin
            case (cycle_limit_mode[2:1])
                2'b00: if (sense.cycle_start) begin
                    cbc_active <= 1'b0;
                    cbc_report <= 1'b0;
                end
                2'b01: begin
                    cbc_active <= 1'b0;
                    cbc_report <= 1'b0;
                end
                2'b10: if (sense.cycle_start) begin
                    if (cbc_count >= cycle_limit_retry_count) begin
                        cbc_active <= 1'b0;
                        cbc_report <= 1'b0;
                    end else begin
                        cbc_count <= cbc_count + 8'h01;
                    end
                end
                default: begin
                    cbc_active <= 1'b0;
                    cbc_report <= 1'b0;
                end
            endcase
        end else begin
            cbc_report <= cbc_report && sense.cycle_over;
        end
    end

    // Lock current: latched modes wait for clear, retry modes run the retry timer in ticks.
    assign lock_tick = tick_count == ($bits(tick_count))'(LOCK_TICK_CYC - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_count <= '0;
        end else begin
            tick_count <= lock_tick ? '0 : tick_count + 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_latched <= 1'b0;
            lock_retry_wait <= 1'b0;
            lock_report <= 1'b0;
            lock_count <= '0;
        end else if (sense.lock_current && !lock_current_mode[3]) begin
            lock_latched <= !lock_current_mode[2];
            lock_retry_wait <= lock_current_mode[2];
            lock_report <= 1'b1;
            lock_count <= '0;
        end else if (sense.lock_current && lock_current_mode == 4'b1000) begin
            lock_report <= 1'b1;
        end else if (lock_retry_wait) begin
            if (lock_tick && lock_count >= lock_retry_time) begin
                lock_retry_wait <= 1'b0;
                lock_report <= 1'b0;
            end else if (lock_tick) begin
                lock_count <= lock_count + 8'h01;
            end
        end else if (clear_fault) begin
            lock_latched <= 1'b0;
            lock_report <= 1'b0;
        end
    end

    // Position detection: ramp timeout and early pulse; set wins over clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_count <= '0;
            rise_timeout <= 1'b0;
            fall_timeout <= 1'b0;
        end else begin
            phase_count <= (sense.rise_phase || sense.fall_phase) ?
                ((phase_count == ($bits(phase_count))'(POS_TIMEOUT_CYC)) ? phase_count : phase_count + 1'b1) : '0;
            if (phase_count == ($bits(phase_count))'(POS_TIMEOUT_CYC) && sense.rise_phase) begin
                rise_timeout <= 1'b1;
            end else if (clear_fault) begin
                rise_timeout <= 1'b0;
            end
            if (phase_count == ($bits(phase_count))'(POS_TIMEOUT_CYC) && sense.fall_phase) begin
                fall_timeout <= 1'b1;
            end else if (clear_fault) begin
                fall_timeout <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_pending <= 1'b0;
            rate_fault <= 1'b0;
        end else begin
            if (sense.pulse_start) begin
                pulse_pending <= 1'b1;
            end else if (sense.pulse_decayed) begin
                pulse_pending <= 1'b0;
            end
            if (sense.pulse_start && pulse_pending && !sense.pulse_decayed) begin
                rate_fault <= 1'b1;
            end else if (clear_fault) begin
                rate_fault <= 1'b0;
            end
        end
    end

    // Thermal: auto mode follows the sensor, latched mode holds until cleared.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thermal_latched <= 1'b0;
        end else if (sense.thermal) begin
            thermal_latched <= 1'b1;
        end else if (thermal_auto_recover || clear_fault) begin
            thermal_latched <= 1'b0;
        end
    end

    // Drive selection: pulled-low faults outrank braking, which outranks recirculation.
    mfrl_drive_t drive;
    logic lock_holds;
    assign lock_holds = lock_latched || lock_retry_wait;
    always_comb begin
        drive = MFRL_DRV_ACTIVE;
        if (thermal_latched || rise_timeout || fall_timeout || rate_fault) begin
            drive = MFRL_DRV_PULL_LOW;
        end else if (lock_holds && lock_current_mode[1:0] == 2'b00) begin
            drive = MFRL_DRV_PULL_LOW;
        end else if (lock_holds && lock_current_mode[1:0] == 2'b10) begin
            drive = MFRL_DRV_HS_BRAKE;
        end else if (lock_holds && lock_current_mode[1:0] == 2'b11) begin
            drive = MFRL_DRV_LS_BRAKE;
        end else if (lock_holds || cbc_active) begin
            drive = MFRL_DRV_RECIRC;
        end
    end

    mfrl_gate_mux u_gate_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .drive(drive),
        .pwm_gates(pwm_gates),
        .gates(gates)
    );

    logic [7:0] ctrl_flags;
    logic [7:0] events;
    assign ctrl_flags = {3'h0, rate_fault, fall_timeout, rise_timeout, lock_report, cbc_report};
    assign events = {2'h0, thermal_latched, ctrl_flags[4:0]};

    // Sticky interrupt status, cleared by reading it; a new event wins over the read.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
            irq <= 1'b0;
            fault_pin_n_out <= 1'b0;
            fault_pin_n_oe <= 1'b0;
        end else begin
            if (do_read && s_axi_araddr == MFRL_ADDR_IRQ_STAT) begin
                irq_stat <= events;
            end else begin
                irq_stat <= irq_stat | events;
            end
            irq <= |(irq_stat & irq_mask);
            fault_pin_n_oe <= |events;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= MFRL_RESP_OK;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= MFRL_RESP_OK;
                case (s_axi_araddr)
                    MFRL_ADDR_CTRL: s_axi_rdata <= ctrl;
                    MFRL_ADDR_CTRL_STAT: s_axi_rdata <= {24'h0, ctrl_flags};
                    MFRL_ADDR_DRV_STAT: s_axi_rdata <= {31'h0, thermal_latched};
                    MFRL_ADDR_IRQ_STAT: s_axi_rdata <= {24'h0, irq_stat};
                    MFRL_ADDR_IRQ_MASK: s_axi_rdata <= {24'h0, irq_mask};
                    MFRL_ADDR_RETRY: s_axi_rdata <= retry;
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= MFRL_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    property p_pull_low_gates;
        @(posedge aclk) disable iff (!aresetn) (rate_fault || thermal_latched) |=> (gates == '0);
    endproperty
    a_pull_low_gates: assert property (p_pull_low_gates) else $error("gates not low during fault");

    property p_cbc_off;
        @(posedge aclk) disable iff (!aresetn) (cycle_limit_mode[3] && sense.cycle_over) |=> !cbc_active;
    endproperty
    a_cbc_off: assert property (p_cbc_off) else $error("cycle limit acted when disabled");

    property p_lock_off;
        @(posedge aclk) disable iff (!aresetn)
            (lock_current_mode > 4'b1000 && !lock_holds && !lock_report) |=> (!lock_holds && !lock_report);
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock fault acted when disabled");

    // The report reaches the pin two edges after the sample: once into the flag, once into the pin register.
    sequence s_lock_seen;
        sense.lock_current && lock_current_mode <= 4'b1000;
    endsequence
    property p_lock_report;
        @(posedge aclk) disable iff (!aresetn) s_lock_seen |=> ##1 fault_pin_n_oe;
    endproperty
    a_lock_report: assert property (p_lock_report) else $error("lock fault not on fault pin");

    property p_rate_fault;
        @(posedge aclk) disable iff (!aresetn) (sense.pulse_start && pulse_pending && !sense.pulse_decayed) |=> rate_fault;
    endproperty
    a_rate_fault: assert property (p_rate_fault) else $error("rate fault missed");

    property p_thermal_latch;
        @(posedge aclk) disable iff (!aresetn)
            (thermal_latched && !sense.thermal && !thermal_auto_recover && !clear_fault) |=> thermal_latched;
    endproperty
    a_thermal_latch: assert property (p_thermal_latch) else $error("thermal fault dropped without clear");

    property p_cbc_next_cycle;
        @(posedge aclk) disable iff (!aresetn)
            (cbc_active && cycle_limit_mode[3:1] == 3'b000 && sense.cycle_start && !sense.cycle_over) |=> !cbc_active;
    endproperty
    a_cbc_next_cycle: assert property (p_cbc_next_cycle) else $error("no resume at cycle start");

    property p_cbc_threshold;
        @(posedge aclk) disable iff (!aresetn)
            (cbc_active && cycle_limit_mode[3:1] == 3'b001 && !sense.cycle_over) |=> !cbc_active;
    endproperty
    a_cbc_threshold: assert property (p_cbc_threshold) else $error("no resume below threshold");

    property p_cbc_count;
        @(posedge aclk) disable iff (!aresetn)
            (cbc_active && cycle_limit_mode[3:1] == 3'b010 && cbc_count < cycle_limit_retry_count && !sense.cycle_over)
            |=> cbc_active;
    endproperty
    a_cbc_count: assert property (p_cbc_count) else $error("resumed before retry count");

    property p_rise_timeout;
        @(posedge aclk) disable iff (!aresetn)
            (phase_count == ($bits(phase_count))'(POS_TIMEOUT_CYC) && sense.rise_phase) |=> rise_timeout;
    endproperty
    a_rise_timeout: assert property (p_rise_timeout) else $error("ramp timeout missed");

    property p_lock_retry;
        @(posedge aclk) disable iff (!aresetn) (lock_retry_wait && !lock_tick && !sense.lock_current) |=> lock_retry_wait;
    endproperty
    a_lock_retry: assert property (p_lock_retry) else $error("retry ended between ticks");
endmodule // mfrl_top
`default_nettype wire

// File: tb/mfrl_host_model.sv
`default_nettype none
module mfrl_host_model (
    // Open-drain fault pin from the device
    input wire logic fault_pin_n_out,
    input wire logic fault_pin_n_oe,
    // Level seen by the host through the board pull-up
    output logic fault_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // A released pin rises to the pull-up level, never to the last driven value.
    assign fault_line = fault_pin_n_oe ? fault_pin_n_out : 1'b1;
endmodule // mfrl_host_model
`default_nettype wire

// File: tb/tb_motor_fault_response_logic.sv
`default_nettype none
module tb_motor_fault_response_logic;
    timeunit 1ns;
    timeprecision 1ns;
    import mfrl_pkg::*;
    // The master is always ready for a response, so back-to-back transfers never drop and raise a ready in one step.
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, irq, od, oe, line;
    mfrl_sense_t sense = '0, s;
    mfrl_gates_t pwm = 6'h2A, gates;
    int err_count = 0, num_checks = 0, cyc = 0;
    mfrl_top #(.POS_TIMEOUT_CYC(100), .LOCK_TICK_CYC(4)) mfrl_top_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sense(sense), .pwm_gates(pwm), .gates(gates), .fault_pin_n_out(od),
        .fault_pin_n_oe(oe), .irq(irq));
    mfrl_host_model mfrl_host_model_inst (.fault_pin_n_out(od), .fault_pin_n_oe(oe), .fault_line(line));
    always #5 aclk = ~aclk;
    // The whole run needs well under this many cycles.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            $display("unexpected at %0t: run hung", $time);
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic rd(input logic [5:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    // Holds the stimulus for a while, then judges the gates and the pin as the host sees them.
    task automatic fault(input mfrl_sense_t v, input int hold, input mfrl_gates_t g, input logic ln);
        sense <= v;
        repeat (hold) @(posedge aclk);
        chk({26'h0, gates}, {26'h0, g}, "gates");
        chk({31'h0, line}, {31'h0, ln}, "fault line");
    endtask
    task automatic clear(input logic [8:0] c);
        sense <= '0;
        wr(MFRL_ADDR_CTRL, {1'b1, 22'h0, c});
        repeat (8) @(posedge aclk);
    endtask
    task automatic test_regs();
        rd(MFRL_ADDR_CTRL); chk(d, MFRL_CTRL_RESET, "ctrl reset");
        rd(MFRL_ADDR_RETRY); chk(d, MFRL_RETRY_RESET, "retry reset");
        rd(6'h18); chk({30'h0, r}, {30'h0, MFRL_RESP_SLVERR}, "unmapped");
        wr(MFRL_ADDR_CTRL_STAT, 32'h1); chk({30'h0, r}, {30'h0, MFRL_RESP_SLVERR}, "read-only");
        $display("register test done");
    endtask
    task automatic test_lock();
        logic [3:0] code [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
        logic [5:0] eg [6] = '{6'h00, 6'h02, 6'h38, 6'h07, 6'h2A, 6'h2A};
        logic el [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        wr(MFRL_ADDR_IRQ_MASK, 32'h3F);
        s = '0;
        s.lock_current = 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(MFRL_ADDR_CTRL, {23'h0, 1'b0, code[i], 4'h7});
            fault(s, 8, eg[i], el[i]);
            if (i == 0) chk({31'h0, irq}, 32'h1, "irq");
            clear({1'b0, code[i], 4'h7});
            chk({26'h0, gates}, {26'h0, pwm}, "lock cleared");
            rd(MFRL_ADDR_IRQ_STAT);
        end
        chk({31'h0, irq}, 32'h0, "irq cleared by read");
        wr(MFRL_ADDR_CTRL, {23'h0, 1'b0, 4'h4, 4'h7});
        fault(s, 8, 6'h00, 1'b0);
        sense <= '0;
        repeat (420) @(posedge aclk);
        chk({26'h0, gates}, {26'h0, pwm}, "lock retry");
        $display("lock test done");
    endtask
    task automatic test_cycle();
        logic [3:0] code [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8};
        logic [5:0] eg [7] = '{6'h02, 6'h02, 6'h02, 6'h02, 6'h2A, 6'h2A, 6'h2A};
        logic el [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 7; i++) begin
            wr(MFRL_ADDR_CTRL, {23'h0, 1'b0, 4'h9, code[i]});
            s = '0;
            s.cycle_over = 1'b1;
            fault(s, 8, eg[i], el[i]);
            // Current dropping without a cycle start must not end a next-cycle recovery.
            if (code[i] < 4'h2) fault('0, 4, 6'h02, el[i]);
            s = '0;
            s.cycle_start = 1'b1;
            // The count-based mode must still recirculate through one more than the retry count of cycle starts.
            repeat ((code[i] == 4'h4) ? int'(MFRL_RETRY_RESET[7:0]) + 1 : 0) begin
                fault(s, 1, 6'h02, 1'b0);
                sense <= '0;
                @(posedge aclk);
            end
            sense <= s;
            @(posedge aclk);
            fault('0, 8, pwm, 1'b1);
        end
        $display("cycle limit test done");
    endtask
    task automatic test_other();
        wr(MFRL_ADDR_CTRL, 32'h97);
        s = '0;
        s.thermal = 1'b1;
        fault(s, 8, 6'h00, 1'b0);
        rd(MFRL_ADDR_DRV_STAT); chk(d, 32'h1, "driver status");
        fault('0, 8, 6'h00, 1'b0);
        clear(9'h97);
        wr(MFRL_ADDR_CTRL, 32'h197);
        fault(s, 8, 6'h00, 1'b0);
        fault('0, 8, pwm, 1'b1);
        for (int k = 0; k < 2; k++) begin
            s = '0;
            s.rise_phase = (k == 0);
            s.fall_phase = (k == 1);
            fault(s, 110, 6'h00, 1'b0);
            rd(MFRL_ADDR_CTRL_STAT);
            chk(d & 32'hC, 32'h4 << k, "ramp timeout");
            clear(9'h97);
        end
        s = '0;
        s.pulse_start = 1'b1;
        sense <= s;
        @(posedge aclk);
        sense <= '0;
        repeat (3) @(posedge aclk);
        fault(s, 1, pwm, 1'b1);
        fault('0, 8, 6'h00, 1'b0);
        $display("thermal and position test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        test_regs();
        test_lock();
        test_cycle();
        test_other();
        close_out();
    end
endmodule // tb_motor_fault_response_logic
`default_nettype wire
